// file: rtl/mul_unit_regs.svh
// constants for the unsigned 8x8 multiply unit: opcodes, address limits and reset values
`ifndef MUL_UNIT_REGS_SVH
`define MUL_UNIT_REGS_SVH

// ==========================================================================
// instruction encodings
`define MUL_LIT_OPCODE 8'h0d
`define MUL_REG_OPCODE 7'h01
`define MUL_OPC_HI 15
`define MUL_OPC_LIT_LO 8
`define MUL_OPC_REG_LO 9
`define MUL_BANK_BIT 8
`define MUL_OPERAND_HI 7
`define MUL_OPERAND_LO 0

// ==========================================================================
// data memory addressing
`define MUL_ACCESS_LIMIT 8'h5f
`define MUL_ACCESS_LOW_BANK 4'h0
`define MUL_ACCESS_HIGH_BANK 4'hf

// ==========================================================================
// reset values
`define MUL_BYTE_RESET 8'h00
`define MUL_WORD_RESET 16'h0000
`define MUL_INSTR_RESET 16'h0000
`define MUL_ADDR_RESET 12'h000

`endif

// file: rtl/mul_unit_pkg.sv
// types shared by the unsigned 8x8 multiply unit
package mul_unit_pkg;

	// ==================================================================
	// quarter-cycle phase, gray coded around the ring
	typedef enum logic [1:0] {
		PH_DECODE = 2'b00,
		PH_READ = 2'b01,
		PH_PROCESS = 2'b11,
		PH_WRITE = 2'b10
	} quarter_t;

	// which multiply the latched word holds
	typedef enum logic [1:0] {
		MUL_NONE = 2'b00,
		MUL_LITERAL = 2'b01,
		MUL_REGISTER = 2'b11
	} mul_kind_t;

endpackage

// file: rtl/unsigned_8x8_multiply_unit.sv
// unsigned 8x8 multiply datapath with its quarter-cycle sequencer
`timescale 1ns/1ns
`default_nettype none
`include "mul_unit_regs.svh"

module unsigned_8x8_multiply_unit (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// instruction from fetch, sampled in the decode quarter
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_word_in,
	// core state used as operands and for addressing
	input wire logic [7:0] accumulator_in,
	input wire logic [3:0] bank_select_register_in,
	input wire logic ext_set_enable_in,
	input wire logic [11:0] index_base_in,
	// data memory read port
	output logic mem_rd_en_out,
	output logic [11:0] mem_rd_addr_out,
	input wire logic [7:0] mem_rd_data_in,
	// write strobes toward the core
	output logic mem_wr_en_out,
	output logic accumulator_wr_en_out,
	output logic status_wr_en_out,
	output logic product_wr_en_out,
	// phase and result
	output mul_unit_pkg::quarter_t quarter_out,
	output logic mul_active_out,
	output logic [7:0] product_high_byte_out,
	output logic [7:0] product_low_byte_out
);
	import mul_unit_pkg::*;

	// ==================================================================
	// shared decoding and arithmetic
	// the byte field serves as register address or as literal
	function automatic logic [7:0] operand_field(input logic [15:0] word);
		operand_field = word[`MUL_OPERAND_HI:`MUL_OPERAND_LO];
	endfunction

	// literal form owns the whole top byte
	function automatic logic is_literal_word(input logic [15:0] word);
		is_literal_word = word[`MUL_OPC_HI:`MUL_OPC_LIT_LO] == `MUL_LIT_OPCODE;
	endfunction

	// register form gives up one opcode bit to the bank select operand
	function automatic logic is_register_word(input logic [15:0] word);
		is_register_word = word[`MUL_OPC_HI:`MUL_OPC_REG_LO] == `MUL_REG_OPCODE;
	endfunction

	// operands widened before the multiply so the high byte is never cut
	function automatic logic [15:0] unsigned_product(input logic [7:0] a, input logic [7:0] b);
		unsigned_product = {8'h00, a} * {8'h00, b};
	endfunction

	// ==================================================================
	// state
	// phase ring and the kind of word taken
	quarter_t quarter_r;
	quarter_t quarter_nxt;
	mul_kind_t kind_r;
	mul_kind_t kind_nxt;
	// latched word and resolved address
	logic [15:0] instr_r;
	logic [11:0] addr_r;
	// datapath pipeline and the product pair
	logic [7:0] operand_r;
	logic [15:0] product_r;
	logic [7:0] product_high_byte_r;
	logic [7:0] product_low_byte_r;

	// ==================================================================
	// decode of the incoming word
	wire is_multiply_literal_op;
	wire is_multiply_register_op;
	wire [7:0] reg_operand;
	wire bank_bit;
	wire indexed_mode;
	wire [11:0] access_addr;
	wire [11:0] banked_addr;
	wire [11:0] indexed_addr;
	wire [11:0] resolved_addr;
	wire low_access;

	// decode looks at the raw word; the latch follows at the decode edge
	assign is_multiply_literal_op =
		is_literal_word(instr_word_in);
	assign is_multiply_register_op =
		is_register_word(instr_word_in);
	assign reg_operand = operand_field(instr_word_in);
	assign bank_bit = instr_word_in[`MUL_BANK_BIT];
	assign low_access = reg_operand <= `MUL_ACCESS_LIMIT;

	// address resolution; the access bank splits at the same boundary
	assign access_addr = low_access ? {`MUL_ACCESS_LOW_BANK, reg_operand}
		: {`MUL_ACCESS_HIGH_BANK, reg_operand};
	assign banked_addr = {bank_select_register_in, reg_operand};
	// indexed form wraps inside the 12-bit space, carry dropped
	assign indexed_addr = index_base_in + {4'h0, reg_operand};
	assign indexed_mode = !bank_bit && ext_set_enable_in && low_access;
	assign resolved_addr = bank_bit ? banked_addr
		: (indexed_mode ? indexed_addr : access_addr);

	// ==================================================================
	// next-state terms
	// one instruction cycle is four quarters from decode:
	// decode latches the word, its kind and the resolved address
	// read takes the operand byte, from memory or from the literal
	// process forms the product with the accumulator of that quarter
	// write moves both bytes out at the same edge
	// accumulator taken late on purpose, so an update just before
	// this word is seen; the price is that it must hold through process
	// a word offered outside decode is dropped without any sign
	always_comb begin
		case (quarter_r)
			PH_DECODE: quarter_nxt = PH_READ;
			PH_READ: quarter_nxt = PH_PROCESS;
			PH_PROCESS: quarter_nxt = PH_WRITE;
			PH_WRITE: quarter_nxt = PH_DECODE;
			default: quarter_nxt = PH_DECODE;
		endcase
	end

	// a new word is only taken in the decode quarter
	// anything but a multiply leaves the product pair alone
	always_comb begin
		kind_nxt = kind_r;
		if (quarter_r == PH_DECODE) begin
			if (!instr_valid_in)
				kind_nxt = MUL_NONE;
			else if (is_multiply_literal_op)
				kind_nxt = MUL_LITERAL;
			else if (is_multiply_register_op)
				kind_nxt = MUL_REGISTER;
			else
				kind_nxt = MUL_NONE;
		end
	end

	// ==================================================================
	// phase ring and decode latch
	// bank select and index base only matter in decode
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			quarter_r <= PH_DECODE;
			kind_r <= MUL_NONE;
			instr_r <= `MUL_INSTR_RESET;
			addr_r <= `MUL_ADDR_RESET;
		end else begin
			quarter_r <= quarter_nxt;
			kind_r <= kind_nxt;
			if (quarter_r == PH_DECODE) begin
				instr_r <= instr_word_in;
				addr_r <= resolved_addr;
			end
		end
	end

	// ==================================================================
	// operand read in the read quarter; literal comes from the word itself
	// memory data counts only in the read quarter, later it may be stale
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			operand_r <= `MUL_BYTE_RESET;
		else if (quarter_r == PH_READ)
			operand_r <= (kind_r == MUL_LITERAL) ?
				operand_field(instr_r) : mem_rd_data_in;
	end

	// ==================================================================
	// process quarter: both operands zero-extended, so the product is exact
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			product_r <= `MUL_WORD_RESET;
		else if (quarter_r == PH_PROCESS)
			product_r <= unsigned_product(accumulator_in, operand_r);
	end

	// ==================================================================
	// write quarter: both bytes land together, never a half
	// an idle cycle never writes, so the last product stands
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			product_high_byte_r <= `MUL_BYTE_RESET;
			product_low_byte_r <= `MUL_BYTE_RESET;
		end else if (quarter_r == PH_WRITE && kind_r != MUL_NONE) begin
			product_high_byte_r <= product_r[15:8];
			product_low_byte_r <= product_r[7:0];
		end
	end

	// ==================================================================
	// outputs; the source register and accumulator are only ever read
	// no write path back to memory, accumulator or flags exists at all,
	// so a zero product cannot disturb any flag either
	assign mem_rd_en_out = quarter_r == PH_READ && kind_r == MUL_REGISTER;
	assign mem_rd_addr_out = addr_r;
	assign mem_wr_en_out = 1'b0;
	assign accumulator_wr_en_out = 1'b0;
	assign status_wr_en_out = 1'b0;
	assign product_wr_en_out = quarter_r == PH_WRITE && kind_r != MUL_NONE;
	assign quarter_out = quarter_r;
	assign mul_active_out = kind_r != MUL_NONE;
	assign product_high_byte_out = product_high_byte_r;
	assign product_low_byte_out = product_low_byte_r;

endmodule

`default_nettype wire

// file: sim/mul_unit_properties.sv
// port-level checker for the multiply unit
`timescale 1ns/1ns
`default_nettype none
module mul_unit_checker (
	// clock, reset and request
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_word_in,
	input wire logic [3:0] bank_select_register_in,
	// watched outputs
	input wire logic mem_rd_en_out,
	input wire logic [11:0] mem_rd_addr_out,
	input wire logic mem_wr_en_out,
	input wire logic accumulator_wr_en_out,
	input wire logic status_wr_en_out,
	input wire logic product_wr_en_out,
	input wire mul_unit_pkg::quarter_t quarter_out,
	input wire logic mul_active_out,
	input wire logic [7:0] product_high_byte_out,
	input wire logic [7:0] product_low_byte_out
);
	import mul_unit_pkg::*;
	// ==============================================================
	// decode of a taken word
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	wire logic take_w = quarter_out == PH_DECODE && instr_valid_in;
	wire logic lit_w = take_w && instr_word_in[15:8] == 8'h0d;
	wire logic reg_w = take_w && instr_word_in[15:9] == 7'h01;
	AST_LIT_WRITE: assert property (lit_w |-> ##3 product_wr_en_out)
		else $error("literal multiply did not write in the fourth quarter");
	AST_REG_READ: assert property (reg_w |=> mem_rd_en_out ##2 product_wr_en_out)
		else $error("register multiply read or write out of place");
	AST_BANK_ADDR: assert property (reg_w && instr_word_in[8] |=>
		mem_rd_addr_out == {$past(bank_select_register_in), $past(instr_word_in[7:0])})
		else $error("banked address not formed from bank select");
	AST_RING: assert property (quarter_out == PH_DECODE |=> quarter_out == PH_READ)
		else $error("decode quarter not followed by read quarter");
	AST_PWR_Q4: assert property (product_wr_en_out |->
		quarter_out == PH_WRITE && mul_active_out)
		else $error("product written outside the write quarter");
	AST_RD_Q2: assert property (mem_rd_en_out |-> quarter_out == PH_READ)
		else $error("operand read outside the read quarter");
	AST_HOLD: assert property (!product_wr_en_out |=>
		$stable({product_high_byte_out, product_low_byte_out}))
		else $error("product changed without a write");
	AST_NO_FLAGS: assert property (!status_wr_en_out)
		else $error("status write strobe raised");
	AST_KEEP_OPS: assert property (!accumulator_wr_en_out && !mem_wr_en_out)
		else $error("operand write strobe raised");
endmodule
bind unsigned_8x8_multiply_unit mul_unit_checker chk (.ref_clk_in(ref_clk_in),
	.reset_n_in(reset_n_in), .instr_valid_in(instr_valid_in), .instr_word_in(instr_word_in),
	.bank_select_register_in(bank_select_register_in), .mem_rd_en_out(mem_rd_en_out),
	.mem_rd_addr_out(mem_rd_addr_out), .mem_wr_en_out(mem_wr_en_out),
	.accumulator_wr_en_out(accumulator_wr_en_out), .status_wr_en_out(status_wr_en_out),
	.product_wr_en_out(product_wr_en_out), .quarter_out(quarter_out),
	.mul_active_out(mul_active_out), .product_high_byte_out(product_high_byte_out),
	.product_low_byte_out(product_low_byte_out));
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the multiply unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import mul_unit_pkg::*;
	typedef struct packed {
		logic [15:0] word;
		logic [7:0] acc;
		logic [7:0] data;
		logic [3:0] bank_select_register;
		logic ext;
		logic [11:0] base;
		logic [11:0] addr;
	} row_t;
	// ==============================================================
	// stimulus and observed signals
	logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, ext = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [7:0] acc = 8'h00, data = 8'h00, ph, pl;
	logic [3:0] bank_select_register = 4'h0;
	logic [11:0] base = 12'h000, addr;
	logic rd_en, wr_en, acc_we, st_we, p_we, active;
	quarter_t q;
	int fails = 0, checks = 0, cycles = 0;
	// bank 9 on access rows shows the bank select is ignored there
	row_t rows [6] = '{'{16'h0dc4, 8'he2, 8'h00, 4'h0, 1'b0, 12'h000, 12'h000},
		'{16'h0312, 8'hc4, 8'hb5, 4'h3, 1'b1, 12'h700, 12'h312},
		'{16'h0250, 8'hff, 8'hff, 4'h9, 1'b0, 12'h000, 12'h050},
		'{16'h02a0, 8'h00, 8'h7f, 4'h9, 1'b1, 12'h123, 12'hfa0},
		'{16'h025f, 8'h01, 8'h80, 4'h9, 1'b1, 12'hfb0, 12'h00f},
		'{16'h0d00, 8'h9c, 8'h55, 4'h0, 1'b0, 12'h000, 12'h000}};
	unsigned_8x8_multiply_unit dut (.ref_clk_in(clk), .reset_n_in(rst_n), .instr_valid_in(vld),
		.instr_word_in(word), .accumulator_in(acc), .bank_select_register_in(bank_select_register),
		.ext_set_enable_in(ext), .index_base_in(base), .mem_rd_en_out(rd_en),
		.mem_rd_addr_out(addr), .mem_rd_data_in(data), .mem_wr_en_out(wr_en),
		.accumulator_wr_en_out(acc_we), .status_wr_en_out(st_we), .product_wr_en_out(p_we),
		.quarter_out(q), .mul_active_out(active), .product_high_byte_out(ph),
		.product_low_byte_out(pl));
	// ==============================================================
	// clock, hang guard and shared tasks
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 500) begin
			fails++;
			test_done;
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one instruction cycle, entered early in the decode quarter, before its decode edge
	task run(input row_t r);
		logic [7:0] op;
		op = r.word[9] ? r.data : r.word[7:0];
		{word, acc, data, bank_select_register, ext, base} = {r.word, r.acc, r.data, r.bank_select_register, r.ext, r.base};
		vld = 1'b1;
		@(posedge clk);
		#5;
		vld = 1'b0;
		if (r.word[9]) chk({4'h0, addr}, {4'h0, r.addr});
		chk({15'h0, rd_en}, {15'h0, r.word[9]});
		repeat (2) @(posedge clk);
		#5;
		chk({15'h0, p_we}, 16'h0001);
		chk({12'h0, active, wr_en, acc_we, st_we}, 16'h0008);
		@(posedge clk);
		#5;
		chk({ph, pl}, {8'h00, r.acc} * {8'h00, op});
	endtask
	task test_done;
		if (fails == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==============================================================
	// table rows, then ignored words and a mid-run reset
	initial begin
		repeat (16) @(posedge clk);
		#5;
		rst_n = 1'b1;
		foreach (rows[i]) run(rows[i]);
		word = 16'h6e12;
		vld = 1'b1;
		@(posedge clk);
		#5;
		{word, acc} = {16'h0dff, 8'hff};
		repeat (3) @(posedge clk);
		#5;
		vld = 1'b0;
		repeat (4) @(posedge clk);
		#5;
		chk({ph, pl}, 16'h0000);
		run(rows[1]);
		rst_n = 1'b0;
		#10;
		chk({ph, pl}, 16'h0000);
		chk({14'h0, q}, 16'h0000);
		@(posedge clk);
		#5;
		rst_n = 1'b1;
		run(rows[0]);
		test_done;
	end
endmodule
`default_nettype wire
